// ### hw/rscc_pkg.sv
// constants and types shared by the strap configuration capture block
package rscc_pkg;

  // core clock rate
  localparam int unsigned CLK_HZ          = 25_000_000;

  // register bus geometry
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 32;

  // register byte addresses
  localparam logic [3:0]  OFS_CONFIG      = 4'h0;
  localparam logic [3:0]  OFS_STATUS      = 4'h4;

  // strap width on the expansion address pins
  localparam int unsigned STRAP_W         = 24;

  // configuration register field positions, mirroring the strap pins
  localparam int unsigned BIT_FLASH_BYTE  = 0;
  localparam int unsigned BIT_PCI_HOST    = 1;
  localparam int unsigned BIT_ARB_EN      = 2;
  localparam int unsigned BIT_WIDE_FLASH  = 7;
  localparam int unsigned BIT_SPEED_LOW   = 21;
  localparam int unsigned BIT_SPEED_HIGH  = 22;
  localparam int unsigned BIT_SPEED_OVR_N = 23;

  // bits captured right after reset and bits captured before clock lock
  localparam logic [31:0] CFG_BOOT_MASK   = 32'h0000_0087;
  localparam logic [31:0] CFG_SPEED_MASK  = 32'h00e0_0000;
  localparam logic [31:0] CFG_WR_MASK     = 32'h00e0_0087;

  // reset value: flash byte-mode bit defaults high
  localparam logic [31:0] CFG_RESET       = 32'h0000_0001;

  // status register field positions
  localparam int unsigned ST_SPEED_LSB    = 0;
  localparam int unsigned ST_BOOT_DONE    = 4;
  localparam int unsigned ST_SPEED_DONE   = 5;
  localparam int unsigned ST_WIDE_ERR     = 6;

  // core speed codes, ordered slowest first so that min is a compare
  typedef enum logic [1:0] {
    RSCC_MHZ_266,
    RSCC_MHZ_400,
    RSCC_MHZ_533,
    RSCC_MHZ_667
  } rscc_speed_t;

  // capture sequence
  typedef enum logic [1:0] {
    CAP_BOOT,
    CAP_WAIT_LOCK,
    CAP_DONE
  } rscc_cap_state_t;

endpackage : rscc_pkg

// ### hw/rscc_speed_resolve.sv
// core speed resolution from factory grade and captured speed straps
`timescale 1ns/100ps
module rscc_speed_resolve
  import rscc_pkg::*;
(
  // factory grade and straps
  input  rscc_pkg::rscc_speed_t factory_grade,
  input  wire logic             speed_override_n,
  input  wire logic             speed_select_low,
  input  wire logic             speed_select_high,
  // resolved speed
  output rscc_pkg::rscc_speed_t core_speed
);
  import rscc_pkg::*;

  rscc_speed_t requested;   // speed asked for by the straps

  // decode the select pattern into a requested speed
  always_comb begin
    requested = factory_grade;
    if (!speed_override_n) begin
      case ({speed_select_high, speed_select_low})
        2'b00:   requested = factory_grade;   // keep grade
        2'b01:   requested = RSCC_MHZ_533;    // low set only
        2'b10:   requested = RSCC_MHZ_266;    // high set only
        2'b11:   requested = RSCC_MHZ_400;    // both set
        default: requested = factory_grade;
      endcase
    end
  end

  // never run faster than the grade; slowest grade is fixed
  always_comb begin
    if (factory_grade == RSCC_MHZ_266) begin
      core_speed = RSCC_MHZ_266;
    end else if (requested > factory_grade) begin
      core_speed = factory_grade;
    end else begin
      core_speed = requested;
    end
  end

endmodule // rscc_speed_resolve

// ### hw/rscc_byte_lane.sv
// expansion data pin drive for 8-bit and 16-bit cycles
`timescale 1ns/100ps
module rscc_byte_lane
  import rscc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // cycle request
  input  wire logic        byte_mode,
  input  wire logic        write_cycle,
  input  wire logic        read_cycle,
  input  wire logic [15:0] write_data,
  // data pins
  output logic      [15:0] exp_data_bus_out,
  output logic      [15:0] exp_data_bus_oe
);
  import rscc_pkg::*;

  // registered pin drive; reads always release the whole bus
  always_ff @(posedge core_clk) begin
    if (rst) begin
      exp_data_bus_out <= 16'h0000;
      exp_data_bus_oe  <= 16'h0000;
    end else if (write_cycle && !read_cycle) begin
      exp_data_bus_oe  <= 16'hffff;
      if (byte_mode) begin
        // upper lane carries no meaning; echo the low byte
        exp_data_bus_out <= {write_data[7:0], write_data[7:0]};
      end else begin
        exp_data_bus_out <= write_data;
      end
    end else begin
      // read or idle: upper lines 15:8 released as well
      exp_data_bus_out <= 16'h0000;
      exp_data_bus_oe  <= 16'h0000;
    end
  end

endmodule // rscc_byte_lane

// ### hw/rscc_top.sv
// boot strap capture, configuration register and derived settings
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module rscc_top
  import rscc_pkg::*;
#(
  parameter int unsigned ADDR_BITS = rscc_pkg::ADDR_W
)
(
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // strap pins and clock synthesizer
  input  wire logic [rscc_pkg::STRAP_W-1:0] exp_address_bus,
  input  wire logic                         pll_lock,
  input  rscc_pkg::rscc_speed_t             factory_grade,
  // register port
  input  wire logic [ADDR_BITS-1:0]         reg_addr,
  input  wire logic [rscc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [rscc_pkg::DATA_W-1:0]  reg_rdata,
  // derived configuration
  output logic                              bus_arbiter_enable_strap,
  output logic                              pci_host_mode,
  output logic                              flash_byte_mode,
  output logic                              wide_flash_error,
  output rscc_pkg::rscc_speed_t             core_speed,
  output logic                              core_speed_valid,
  output logic                              boot_capture_done,
  // expansion data cycle request
  input  wire logic                         exp_write_cycle,
  input  wire logic                         exp_read_cycle,
  input  wire logic [15:0]                  exp_write_data,
  // expansion data pins
  output logic      [15:0]                  exp_data_bus_out,
  output logic      [15:0]                  exp_data_bus_oe
);
  import rscc_pkg::*;

  // refuse an address port too narrow for the status offset
  if (ADDR_BITS < 3) begin : g_addr_check
    $error("rscc_top: ADDR_BITS must be at least 3");
  end

  // strap word plus zero pad must fill the register word
  if (STRAP_W + 8 != DATA_W) begin : g_strap_check
    $error("rscc_top: strap width must be DATA_W minus 8");
  end

  // speed straps must sit inside the strap word
  if (BIT_SPEED_OVR_N >= STRAP_W) begin : g_speed_bit_check
    $error("rscc_top: speed strap bits outside the strap word");
  end

  // capture sequence state
  rscc_cap_state_t          state;
  rscc_cap_state_t          next_state;

  // configuration register and its next value
  logic [DATA_W-1:0]        boot_strap_config;
  logic [DATA_W-1:0]        next_config;

  // decoded register strobes
  logic                     hit_config;
  logic                     hit_status;
  logic                     cfg_write;

  // status word and read mux
  logic [DATA_W-1:0]        status_word;
  logic [DATA_W-1:0]        next_rdata;

  // straps taken as already synchronous to core_clk;
  // the board holds them steady around reset release
  // combinational speed from the resolver
  rscc_speed_t              resolved_speed;

  // address decode, byte addresses with the unused high bits zero
  // only two word offsets answer; any other address reads zero
  // and takes no write
  always_comb begin
    hit_config = (reg_addr == ADDR_BITS'(OFS_CONFIG));
    hit_status = (reg_addr == ADDR_BITS'(OFS_STATUS));
    cfg_write  = reg_wr && hit_config;
  end

  // boot straps taken exactly once, on the first edge after reset;
  // speed straps keep following the pins until lock, so a late
  // board settle still lands in the register
  // lock in the very first cycle still passes through the wait step
  // next state of the capture sequence
  always_comb begin
    next_state = state;
    case (state)
      // first edge after reset release takes the boot straps
      CAP_BOOT: begin
        next_state = CAP_WAIT_LOCK;
      end
      // keep sampling speed straps until the synthesizer locks
      CAP_WAIT_LOCK: begin
        if (pll_lock) begin
          next_state = CAP_DONE;
        end
      end
      // hold everything until the next reset
      CAP_DONE: begin
        next_state = CAP_DONE;
      end
      default: begin
        // unreachable encoding, restart the capture
        next_state = CAP_BOOT;
      end
    endcase
  end

  // sequence register
  // a new reset always restarts from the boot step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= CAP_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // order of the three updates matters:
  // boot bits only in the first cycle after reset,
  // speed bits on every unlocked cycle until the first lock,
  // software write last so it wins in the same cycle;
  // speed bits written before lock are overwritten by the pins,
  // so software should wait for the speed valid flag
  // next configuration value: strap capture, then software write
  always_comb begin
    next_config = boot_strap_config;
    // boot straps: arbiter, host role, flash widths
    if (state == CAP_BOOT) begin
      next_config = (next_config & ~CFG_BOOT_MASK)
                  | ({8'h00, exp_address_bus} & CFG_BOOT_MASK);
    end
    // speed straps follow the pins only while unlocked
    if ((state == CAP_BOOT || state == CAP_WAIT_LOCK) && !pll_lock) begin
      next_config = (next_config & ~CFG_SPEED_MASK)
                  | ({8'h00, exp_address_bus} & CFG_SPEED_MASK);
    end
    // software write lands on the writable bits last
    if (cfg_write) begin
      next_config = (next_config & ~CFG_WR_MASK)
                  | (reg_wdata & CFG_WR_MASK);
    end
  end

  // configuration register; width bit held high through reset
  // byte mode by default, so a board with no pull-down on pin 0
  // still boots from a narrow flash
  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_strap_config <= CFG_RESET;
    end else begin
      boot_strap_config <= next_config;
    end
  end

  // speed resolution from the captured straps
  // only ever lowers the grade; a pattern asking for more than
  // the part can do falls back to the grade
  rscc_speed_resolve u_speed (
    .factory_grade     (factory_grade),
    .speed_override_n  (boot_strap_config[BIT_SPEED_OVR_N]),
    .speed_select_low  (boot_strap_config[BIT_SPEED_LOW]),
    .speed_select_high (boot_strap_config[BIT_SPEED_HIGH]),
    .core_speed        (resolved_speed)
  );

  // registered core speed, reset to the slowest safe grade
  // one edge behind the register, so the clock logic never sees
  // a half-decoded pattern
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_speed <= RSCC_MHZ_266;
    end else begin
      core_speed <= resolved_speed;
    end
  end

  // speed valid once the lock has frozen the speed straps
  // rises on the freezing edge; software polls it before trusting
  // the speed field of the status word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_speed_valid <= 1'b0;
    end else begin
      core_speed_valid <= (next_state == CAP_DONE);
    end
  end

  // boot straps taken flag
  // set once, cleared only by reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_capture_done <= 1'b0;
    end else if (state == CAP_BOOT) begin
      boot_capture_done <= 1'b1;
    end
  end

  // arbiter enable and host role straight from their bits
  // taken from the next value so outputs change on the same edge
  // as the register, for capture and software write alike
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_arbiter_enable_strap <= 1'b0;
      pci_host_mode            <= 1'b0;
    end else begin
      bus_arbiter_enable_strap <= next_config[BIT_ARB_EN];
      pci_host_mode            <= next_config[BIT_PCI_HOST];
    end
  end

  // boot flash width: 1 is byte mode, 0 is 16-bit mode
  // byte mode after reset matches the register reset value;
  // the lane logic reads it to decide how to drive lines 15:8
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flash_byte_mode <= 1'b1;
    end else begin
      flash_byte_mode <= next_config[BIT_FLASH_BYTE];
    end
  end

  // unsupported wide flash strap reported as a level
  // the board keeps pin 7 low, so a high level here points at a
  // missing pull-down or a stray software write;
  // it never blocks the boot
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wide_flash_error <= 1'b0;
    end else begin
      wide_flash_error <= next_config[BIT_WIDE_FLASH];
    end
  end

  // status word, reserved bits zero
  // read-only view of the derived state
  always_comb begin
    status_word = '0;
    status_word[ST_SPEED_LSB +: 2] = core_speed;
    status_word[ST_BOOT_DONE]      = boot_capture_done;
    status_word[ST_SPEED_DONE]     = core_speed_valid;
    status_word[ST_WIDE_ERR]       = wide_flash_error;
  end

  // read mux; unmapped or idle gives zero
  // reads have no side effects, so back-to-back reads are safe
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      if (hit_config) begin
        next_rdata = boot_strap_config;
      end else if (hit_status) begin
        next_rdata = status_word;
      end
    end
  end

  // read data stand for the one cycle after the strobe
  // zero outside the answer cycle keeps a shared read bus quiet;
  // the master takes the word only in that one cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // expansion data pins follow the captured flash width
  // writes drive all sixteen lines; reads release every line
  // so the flash can drive the low byte;
  // the upper lane value in byte mode carries no meaning
  rscc_byte_lane u_lane (
    .core_clk         (core_clk),
    .rst              (rst),
    .byte_mode        (flash_byte_mode),
    .write_cycle      (exp_write_cycle),
    .read_cycle       (exp_read_cycle),
    .write_data       (exp_write_data),
    .exp_data_bus_out (exp_data_bus_out),
    .exp_data_bus_oe  (exp_data_bus_oe)
  );

endmodule // rscc_top

// ### bench/rscc_strap_board.sv
// board strap resistors on the expansion address pins
`timescale 1ns/100ps
module rscc_strap_board
  import rscc_pkg::*;
(
  // clock and strapping window
  input  wire logic                         core_clk,
  input  wire logic                         strap_phase,
  // fitted pull-ups, one bit a pin
  input  wire logic [rscc_pkg::STRAP_W-1:0] pulls,
  // pins seen by the device
  output logic      [rscc_pkg::STRAP_W-1:0] exp_address_bus
);
  import rscc_pkg::*;
  logic [STRAP_W-1:0] traffic = 24'h000000;  // live addresses after boot
  // address traffic changes every cycle once strapping is over
  always_ff @(posedge core_clk) begin
    traffic <= traffic + 24'h5ac3e7;
  end
  // pin 7 always has its pull-down fitted
  assign exp_address_bus = strap_phase ? (pulls & 24'hffff7f)
                                       : traffic;
endmodule // rscc_strap_board

// ### bench/rscc_top_chk.sv
// port assertions for the strap capture block
`timescale 1ns/100ps
module rscc_chk
  import rscc_pkg::*;
(
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // straps, lock and bus
  input  wire logic [rscc_pkg::STRAP_W-1:0] exp_address_bus,
  input  wire logic                         pll_lock,
  input  rscc_pkg::rscc_speed_t             factory_grade,
  input  wire logic                         reg_wr,
  input  wire logic                         exp_write_cycle,
  input  wire logic                         exp_read_cycle,
  // derived outputs
  input  wire logic                         bus_arbiter_enable_strap,
  input  wire logic                         pci_host_mode,
  input  wire logic                         flash_byte_mode,
  input  rscc_pkg::rscc_speed_t             core_speed,
  input  wire logic                         core_speed_valid,
  input  wire logic [15:0]                  exp_data_bus_oe
);
  import rscc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0]         rst_q;  // reset history
  logic               wr_q;   // write in previous cycle
  logic [STRAP_W-1:0] pin_q;  // pins at previous edge
  logic               cap_t;  // first sample after capture edge
  // history of reset, writes and pins
  always_ff @(posedge core_clk) begin
    rst_q <= {rst_q[0], rst};
    wr_q  <= reg_wr;
    pin_q <= exp_address_bus;
  end
  assign cap_t = !rst && !rst_q[0] && rst_q[1] && !wr_q;
  logic boot_q_ok;  // settled after capture, no write seen
  assign boot_q_ok = !rst && !rst_q[0] && !rst_q[1] && !wr_q;
  arb_capture_a: assert property (
    cap_t |-> bus_arbiter_enable_strap == pin_q[BIT_ARB_EN])
    else $error("arbiter enable differs from strap");
  host_capture_a: assert property (
    cap_t |-> pci_host_mode == pin_q[BIT_PCI_HOST])
    else $error("host mode differs from strap");
  width_capture_a: assert property (
    cap_t |-> flash_byte_mode == pin_q[BIT_FLASH_BYTE])
    else $error("flash width differs from strap");
  lock_gate_a: assert property (
    !pll_lock && !core_speed_valid |=> !core_speed_valid)
    else $error("speed valid before lock");
  speed_cap_a: assert property (
    core_speed_valid |-> core_speed <= factory_grade)
    else $error("core speed above factory grade");
  read_release_a: assert property (
    exp_read_cycle |=> exp_data_bus_oe == 16'h0000)
    else $error("data pins driven in read");
  byte_drive_a: assert property (
    flash_byte_mode && exp_write_cycle && !exp_read_cycle
    |=> exp_data_bus_oe == 16'hffff)
    else $error("data pins not driven in write");
  width_reset_a: assert property (disable iff (1'b0)
    rst |=> flash_byte_mode)
    else $error("width bit low after reset edge");
  strap_hold_a: assert property (
    boot_q_ok |-> $stable(bus_arbiter_enable_strap) && $stable(pci_host_mode))
    else $error("straps changed without write");
  cover property (core_speed_valid && core_speed < factory_grade);
  cover property (flash_byte_mode && exp_write_cycle);
  cover property (cap_t && !flash_byte_mode);
endmodule // rscc_chk
bind rscc_top rscc_chk u_chk (.core_clk, .rst, .exp_address_bus, .pll_lock,
  .factory_grade, .reg_wr, .exp_write_cycle, .exp_read_cycle,
  .bus_arbiter_enable_strap, .pci_host_mode, .flash_byte_mode, .core_speed,
  .core_speed_valid, .exp_data_bus_oe);

// ### bench/rscc_top_bench.sv
// self-checking bench for the strap capture block
`timescale 1ns/100ps
module rscc_top_bench;
  import rscc_pkg::*;
  logic               core_clk = 1'b0;        // 25 MHz clock
  logic               rst = 1'b1;             // sync reset
  logic               pll_lock = 1'b0;        // synthesizer lock
  rscc_speed_t        factory_grade = RSCC_MHZ_266;
  logic [STRAP_W-1:0] pulls = 24'h000000;     // fitted pull-ups
  logic [STRAP_W-1:0] exp_address_bus;        // strap pins
  logic [3:0]         reg_addr = 4'h0;        // register port
  logic [31:0]        reg_wdata = 32'h0, reg_rdata;
  logic               reg_wr = 1'b0, reg_rd = 1'b0;
  logic               bus_arbiter_enable_strap, pci_host_mode;
  logic               flash_byte_mode, wide_flash_error;
  rscc_speed_t        core_speed;
  logic               core_speed_valid, boot_capture_done;
  logic               exp_write_cycle = 1'b0, exp_read_cycle = 1'b0;
  logic [15:0]        exp_write_data = 16'h0, exp_data_bus_out;
  logic [15:0]        exp_data_bus_oe;
  int                 num_errors = 0, checked = 0, seed, n, sp;
  logic [31:0]        r, w;
  always #20 core_clk = ~core_clk;
  rscc_strap_board u_board (.core_clk, .strap_phase(rst || !pll_lock),
    .pulls, .exp_address_bus);
  rscc_top dut (.core_clk, .rst, .exp_address_bus, .pll_lock,
    .factory_grade, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_arbiter_enable_strap, .pci_host_mode, .flash_byte_mode,
    .wide_flash_error, .core_speed, .core_speed_valid, .boot_capture_done,
    .exp_write_cycle, .exp_read_cycle, .exp_write_data, .exp_data_bus_out,
    .exp_data_bus_oe);
  // compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write cycle
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // one read cycle, data compared in the cycle after
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // model of the speed table, slowest code first
  function automatic int exp_speed(int g, int s);
    int q;
    q = (s > 3) ? g : (s == 1) ? 2 : (s == 2) ? 0 : (s == 3) ? 1 : g;
    return (q < g) ? q : g;
  endfunction
  // verdict and end of run
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // every grade against every speed strap pattern
  initial begin
    seed = 32'h9cfd489f;
    for (int k = 0; k < 32; k++) begin
      r = $random(seed);
      w = $random(seed);
      @(posedge core_clk);
      rst <= 1'b1;
      pll_lock <= 1'b0;
      pulls <= {k[2:0], r[20:0]};
      factory_grade <= rscc_speed_t'(k[4:3]);
      repeat (12) @(posedge core_clk);
      #1 chk(flash_byte_mode, 32'h1);
      @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      pll_lock <= 1'b1;
      for (n = 0; n < 10 && core_speed_valid !== 1'b1; n++)
        @(posedge core_clk) #1;
      if (n == 10) begin
        num_errors++;
        stop_test;
      end
      @(posedge core_clk) #1;
      sp = exp_speed(k[4:3], k[2:0]);
      chk(bus_arbiter_enable_strap, r[2]);
      chk(pci_host_mode, r[1]);
      chk(flash_byte_mode, r[0]);
      chk(core_speed, sp);
      chk(wide_flash_error, 32'h0);
      rd_chk(OFS_CONFIG, {8'h0, k[2:0], r[20:0]} & 32'h00e00007);
      rd_chk(OFS_STATUS, 32'h30 | sp);
      rd_chk(4'h8, 32'h0);
      reg_write(OFS_CONFIG, w);
      #1 chk(flash_byte_mode, w[0]);
      chk(wide_flash_error, w[7]);
      rd_chk(OFS_CONFIG, w & CFG_WR_MASK);
      @(posedge core_clk);
      exp_write_cycle <= 1'b1;
      exp_write_data <= r[31:16];
      @(posedge core_clk);
      exp_write_cycle <= 1'b0;
      exp_read_cycle <= 1'b1;
      #1 chk(exp_data_bus_oe, 32'hffff);
      chk(exp_data_bus_out[7:0], r[23:16]);
      chk(exp_data_bus_out[15:8], w[0] ? r[23:16] : r[31:24]);
      @(posedge core_clk);
      exp_read_cycle <= 1'b0;
      #1 chk(exp_data_bus_oe, 32'h0);
      chk(exp_data_bus_out, 32'h0);
    end
    stop_test;
  end
endmodule // rscc_top_bench
